// file: rtl/shc_pkg.sv
// constants, command codes and carrier types of the status/heater block
// assumes the two-byte command set of an i2c sensor target
package shc_pkg;
   localparam logic [6:0] TARGET_ADDR = 7'h4A;
   localparam logic [7:0] CMD_GROUP_MSB = 8'h30;
   localparam logic [7:0] CMD_HEATER_ON_LSB = 8'h6D;
   localparam logic [7:0] CMD_HEATER_OFF_LSB = 8'h66;
   localparam logic [7:0] CMD_CLEAR_LSB = 8'h41;
   localparam logic [7:0] CMD_READ_MSB = 8'hF3;
   localparam logic [7:0] CMD_READ_LSB = 8'h2D;
   localparam logic [7:0] CRC_POLY = 8'h31;
   localparam logic [7:0] CRC_INIT = 8'hFF;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [1:0] RX_CMD_BYTES = 2'h2;
   localparam logic [1:0] RX_CRC_BYTES = 2'h3;
   localparam logic [1:0] TX_HI = 2'h0;
   localparam logic [1:0] TX_LO = 2'h1;
   localparam logic [1:0] TX_CRC = 2'h2;
   localparam logic [1:0] TX_DONE = 2'h3;
   localparam int BIT_ALERT = 15;
   localparam int BIT_HEATER = 13;
   localparam int BIT_HUM_ALERT = 11;
   localparam int BIT_TEMP_ALERT = 10;
   localparam int BIT_RESET_SEEN = 4;
   localparam int BIT_CMD_ERR = 1;
   localparam int BIT_CRC_ERR = 0;
   localparam logic [15:0] STATUS_ZERO = 16'h0000;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
      logic [7:0] crc_rx;
      logic [1:0] n_bytes;
   } shc_cmd_t;

   typedef enum logic [5:0] {
      L_IDLE = 6'b000001,
      L_ADDR = 6'b000010,
      L_ACK  = 6'b000100,
      L_WR   = 6'b001000,
      L_RD   = 6'b010000,
      L_RACK = 6'b100000
   } shc_link_state_t;
endpackage : shc_pkg

// file: rtl/shc_sync2.sv
// two-flop synchroniser for a level crossing into the given clock
// assumes input is quasi-static relative to the destination clock
`timescale 1ns/1ps
module shc_sync2 (
   input wire logic clk_i,
   input wire logic d_i,
   output logic q_o
);
   logic meta_reg;

   always_ff @(posedge clk_i) begin
      meta_reg <= d_i;
      q_o <= meta_reg;
   end
endmodule : shc_sync2

// file: rtl/shc_top.sv
// status word, heater control and i2c target of the sensor core
// assumes LINK_CLK_I free-running, SCL/SDA open drain resolved outside
`timescale 1ns/1ps
module shc_top
   import shc_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic LINK_CLK_I,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_N_O,
   input wire logic EXTERNAL_RESET_PIN_N_I,
   input wire logic HUM_ALERT_I,
   input wire logic TEMP_ALERT_I,
   output logic HEATER_ON_O,
   output logic [15:0] STATUS_O
);
   function automatic logic [7:0] crc8(input logic [15:0] d);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         if (c[7] ^ d[i]) begin
            c = {c[6:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction : crc8

   // ---------------- core domain ----------------
   logic pin_n_s, core_rst, cmd_tgl_s, cmd_tgl_d_reg;
   logic heater_reg, hum_reg, temp_reg, rst_seen_reg, cmd_err_reg;
   logic crc_err_reg, snap_pend_reg, ack_tgl_reg, cmd_tgl_reg;
   logic [15:0] status_word, snap_reg;
   logic cmd_evt, is_on, is_off, is_clr, is_rd, crc_bad;
   shc_cmd_t cmd_word_reg;

   shc_sync2 u_sync_pin (.clk_i(CORE_CLK_I), .d_i(EXTERNAL_RESET_PIN_N_I),
      .q_o(pin_n_s));
   shc_sync2 u_sync_cmd (.clk_i(CORE_CLK_I), .d_i(cmd_tgl_reg),
      .q_o(cmd_tgl_s));

   assign core_rst = RST_I | ~pin_n_s;
   assign cmd_evt = cmd_tgl_s ^ cmd_tgl_d_reg;
   assign is_on = (cmd_word_reg.hi == CMD_GROUP_MSB) &&
      (cmd_word_reg.lo == CMD_HEATER_ON_LSB);
   assign is_off = (cmd_word_reg.hi == CMD_GROUP_MSB) &&
      (cmd_word_reg.lo == CMD_HEATER_OFF_LSB);
   assign is_clr = (cmd_word_reg.hi == CMD_GROUP_MSB) &&
      (cmd_word_reg.lo == CMD_CLEAR_LSB);
   assign is_rd = (cmd_word_reg.hi == CMD_READ_MSB) &&
      (cmd_word_reg.lo == CMD_READ_LSB);
   assign crc_bad = (cmd_word_reg.n_bytes == RX_CRC_BYTES) &&
      (crc8({cmd_word_reg.hi, cmd_word_reg.lo}) != cmd_word_reg.crc_rx);

   always_ff @(posedge CORE_CLK_I) begin
      if (core_rst) begin
         cmd_tgl_d_reg <= cmd_tgl_s;
      end else begin
         cmd_tgl_d_reg <= cmd_tgl_s; // events during reset are dropped
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (core_rst) begin
         heater_reg <= 1'b0;
      end else if (cmd_evt && is_on) begin
         heater_reg <= 1'b1;
      end else if (cmd_evt && is_off) begin
         heater_reg <= 1'b0;
      end
   end

   // alerts: a new alert wins over a clear in the same cycle
   always_ff @(posedge CORE_CLK_I) begin
      if (core_rst) begin
         hum_reg <= 1'b0;
         temp_reg <= 1'b0;
      end else begin
         hum_reg <= HUM_ALERT_I | (hum_reg & ~(cmd_evt & is_clr));
         temp_reg <= TEMP_ALERT_I | (temp_reg & ~(cmd_evt & is_clr));
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (core_rst) begin
         rst_seen_reg <= 1'b1;
      end else if (cmd_evt && is_clr) begin
         rst_seen_reg <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (core_rst) begin
         cmd_err_reg <= 1'b0;
         crc_err_reg <= 1'b0;
      end else if (cmd_evt) begin
         cmd_err_reg <= ~(is_on | is_off | is_clr | is_rd);
         crc_err_reg <= crc_bad;
      end
   end

   always_comb begin
      status_word = STATUS_ZERO; // reserved bits read zero
      status_word[BIT_ALERT] = hum_reg | temp_reg;
      status_word[BIT_HEATER] = heater_reg;
      status_word[BIT_HUM_ALERT] = hum_reg;
      status_word[BIT_TEMP_ALERT] = temp_reg;
      status_word[BIT_RESET_SEEN] = rst_seen_reg;
      status_word[BIT_CMD_ERR] = cmd_err_reg;
      status_word[BIT_CRC_ERR] = crc_err_reg;
   end

   // snapshot handed back to the link one cycle after a command settles
   always_ff @(posedge CORE_CLK_I) begin
      if (core_rst) begin
         snap_pend_reg <= 1'b0;
         ack_tgl_reg <= 1'b0;
         snap_reg <= STATUS_ZERO;
      end else begin
         snap_pend_reg <= cmd_evt;
         if (snap_pend_reg) begin
            snap_reg <= status_word;
            ack_tgl_reg <= ~ack_tgl_reg;
         end
      end
   end

   assign HEATER_ON_O = heater_reg;
   assign STATUS_O = status_word;

   // ---------------- link domain ----------------
   logic link_rst, busy_l, scl_s, sda_s, scl_d_reg, sda_d_reg, ack_tgl_s;
   logic ack_d_reg, start, stop, rise, fall;
   logic byte_done_reg, rw_reg, wr_xfer_reg, nack_reg, oe_n_reg;
   logic [2:0] cnt_reg;
   logic [7:0] shift_reg, tx_byte;
   logic [7:0] rx_mem [3];
   logic [1:0] rx_cnt_reg, tx_idx_reg;
   logic [15:0] status_l_reg;
   logic [7:0] crc_l_reg;
   shc_link_state_t state_reg;

   shc_sync2 u_sync_rst (.clk_i(LINK_CLK_I), .d_i(RST_I), .q_o(link_rst));
   shc_sync2 u_sync_busy (.clk_i(LINK_CLK_I), .d_i(core_rst), .q_o(busy_l));
   shc_sync2 u_sync_scl (.clk_i(LINK_CLK_I), .d_i(SCL_I), .q_o(scl_s));
   shc_sync2 u_sync_sda (.clk_i(LINK_CLK_I), .d_i(SDA_I), .q_o(sda_s));
   shc_sync2 u_sync_ack (.clk_i(LINK_CLK_I), .d_i(ack_tgl_reg),
      .q_o(ack_tgl_s));

   assign start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
   assign rise = scl_s & ~scl_d_reg;
   assign fall = ~scl_s & scl_d_reg;

   always_comb begin
      if (tx_idx_reg == TX_HI) begin
         tx_byte = status_l_reg[15:8];
      end else if (tx_idx_reg == TX_LO) begin
         tx_byte = status_l_reg[7:0];
      end else if (tx_idx_reg == TX_CRC) begin
         tx_byte = crc_l_reg;
      end else begin
         tx_byte = IDLE_BYTE;
      end
   end

   always_ff @(posedge LINK_CLK_I) begin
      if (link_rst) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   always_ff @(posedge LINK_CLK_I) begin
      if (link_rst) begin
         ack_d_reg <= 1'b0;
         status_l_reg <= STATUS_ZERO;
         crc_l_reg <= CRC_INIT;
      end else begin
         ack_d_reg <= ack_tgl_s;
         if (ack_tgl_s ^ ack_d_reg) begin
            status_l_reg <= snap_reg;
            crc_l_reg <= crc8(snap_reg);
         end
      end
   end

   // command word leaves at stop or repeated start of a write
   always_ff @(posedge LINK_CLK_I) begin
      if (link_rst) begin
         cmd_tgl_reg <= 1'b0;
         cmd_word_reg <= '0;
      end else if ((start | stop) && wr_xfer_reg &&
                   rx_cnt_reg >= RX_CMD_BYTES) begin
         cmd_tgl_reg <= ~cmd_tgl_reg;
         cmd_word_reg <= '{hi: rx_mem[0], lo: rx_mem[1], crc_rx: rx_mem[2],
            n_bytes: rx_cnt_reg};
      end
   end

   always_ff @(posedge LINK_CLK_I) begin
      if (link_rst) begin
         state_reg <= L_IDLE;
         cnt_reg <= 3'h0;
         byte_done_reg <= 1'b0;
         shift_reg <= 8'h00;
         rw_reg <= 1'b0;
         wr_xfer_reg <= 1'b0;
         nack_reg <= 1'b0;
         oe_n_reg <= 1'b1;
         rx_cnt_reg <= 2'h0;
         tx_idx_reg <= TX_HI;
         for (int i = 0; i < 3; i++) begin
            rx_mem[i] <= 8'h00;
         end
      end else if (start) begin
         state_reg <= L_ADDR;
         cnt_reg <= 3'h0;
         byte_done_reg <= 1'b0;
         wr_xfer_reg <= 1'b0;
         rx_cnt_reg <= 2'h0;
         oe_n_reg <= 1'b1;
      end else if (stop) begin
         state_reg <= L_IDLE;
         wr_xfer_reg <= 1'b0;
         oe_n_reg <= 1'b1;
      end else if (rise) begin
         case (state_reg)
            L_ADDR, L_WR: begin
               shift_reg <= {shift_reg[6:0], sda_s};
               cnt_reg <= cnt_reg + 3'h1;
               byte_done_reg <= (cnt_reg == LAST_BIT);
            end
            L_RD: begin
               cnt_reg <= cnt_reg + 3'h1;
               byte_done_reg <= (cnt_reg == LAST_BIT);
            end
            L_RACK: begin
               nack_reg <= sda_s;
            end
            default: begin
            end
         endcase
      end else if (fall) begin
         case (state_reg)
            L_ADDR: begin
               byte_done_reg <= 1'b0;
               if (byte_done_reg) begin
                  // no answer to the address while reset runs
                  if (shift_reg[7:1] == TARGET_ADDR && !busy_l) begin
                     oe_n_reg <= 1'b0;
                     rw_reg <= shift_reg[0];
                     wr_xfer_reg <= ~shift_reg[0];
                     tx_idx_reg <= TX_HI;
                     state_reg <= L_ACK;
                  end else begin
                     state_reg <= L_IDLE;
                  end
               end
            end
            L_WR: begin
               byte_done_reg <= 1'b0;
               if (byte_done_reg) begin
                  if (rx_cnt_reg != TX_DONE) begin
                     rx_mem[rx_cnt_reg] <= shift_reg;
                     rx_cnt_reg <= rx_cnt_reg + 2'h1;
                  end
                  oe_n_reg <= 1'b0;
                  state_reg <= L_ACK;
               end
            end
            L_ACK: begin
               cnt_reg <= 3'h0;
               if (rw_reg) begin
                  shift_reg <= tx_byte;
                  oe_n_reg <= tx_byte[7];
                  state_reg <= L_RD;
               end else begin
                  oe_n_reg <= 1'b1;
                  state_reg <= L_WR;
               end
            end
            L_RD: begin
               if (byte_done_reg) begin
                  byte_done_reg <= 1'b0;
                  oe_n_reg <= 1'b1;
                  if (tx_idx_reg != TX_DONE) begin
                     tx_idx_reg <= tx_idx_reg + 2'h1;
                  end
                  state_reg <= L_RACK;
               end else begin
                  shift_reg <= {shift_reg[6:0], 1'b0};
                  oe_n_reg <= shift_reg[6];
               end
            end
            L_RACK: begin
               if (nack_reg) begin
                  state_reg <= L_IDLE;
               end else begin
                  cnt_reg <= 3'h0;
                  shift_reg <= tx_byte; // next of high, low, crc
                  oe_n_reg <= tx_byte[7];
                  state_reg <= L_RD;
               end
            end
            default: begin
            end
         endcase
      end
   end

   assign SDA_O = 1'b0;
   assign SDA_OE_N_O = oe_n_reg;
endmodule : shc_top

// file: tb/shc_chk.sv
// checker: status word, heater and reset relations at the core ports
// assumes core inputs change just after rising CORE_CLK_I edges
`timescale 1ns/1ps
module shc_chk (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic EXTERNAL_RESET_PIN_N_I,
   input wire logic HUM_ALERT_I,
   input wire logic TEMP_ALERT_I,
   input wire logic HEATER_ON_O,
   input wire logic [15:0] STATUS_O
);
   logic [3:0] pin_h_reg;
   always_ff @(posedge CORE_CLK_I) begin
      pin_h_reg <= {pin_h_reg[2:0], EXTERNAL_RESET_PIN_N_I};
   end
   default clocking @(posedge CORE_CLK_I);
   endclocking
   // quiet while either reset source is still settling
   default disable iff (RST_I || !(&pin_h_reg));
   heater_bit_a: assert property (STATUS_O[13] == HEATER_ON_O)
      else $error("heater bit differs");
   alert_sum_a: assert property (
      STATUS_O[15] == (STATUS_O[11] | STATUS_O[10]))
      else $error("alert summary wrong");
   hum_set_a: assert property (
      HUM_ALERT_I |-> ##[1:2] STATUS_O[11]) else $error("hum alert lost");
   temp_set_a: assert property (
      TEMP_ALERT_I |-> ##[1:2] STATUS_O[10]) else $error("temp alert lost");
   reserved_zero_a: assert property (
      {STATUS_O[14], STATUS_O[12], STATUS_O[9:5], STATUS_O[3:2]} == 9'h000)
      else $error("reserved bit set");
   reset_value_a: assert property (
      $fell(RST_I) |-> STATUS_O == 16'h0010 && !HEATER_ON_O)
      else $error("wrong state after reset");
   pin_reset_a: assert property (disable iff (RST_I)
      $fell(EXTERNAL_RESET_PIN_N_I) |-> ##4 STATUS_O[4] && !HEATER_ON_O)
      else $error("pin reset ignored");
   heater_ok_a: assert property (
      $rose(HEATER_ON_O) |-> !STATUS_O[1]) else $error("heater on flagged");
   bad_cmd_a: assert property (
      $rose(STATUS_O[1]) |-> $stable(HEATER_ON_O))
      else $error("bad command acted on");
   cover property ($rose(HEATER_ON_O));
   cover property ($rose(STATUS_O[1]));
   cover property ($fell(STATUS_O[4]));
endmodule : shc_chk
bind shc_top shc_chk shc_chk_i (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I),
   .EXTERNAL_RESET_PIN_N_I(EXTERNAL_RESET_PIN_N_I),
   .HUM_ALERT_I(HUM_ALERT_I), .TEMP_ALERT_I(TEMP_ALERT_I),
   .HEATER_ON_O(HEATER_ON_O), .STATUS_O(STATUS_O));

// file: tb/shc_master.sv
// partner model: i2c bus master driving scl and sda open drain
// assumes the bench resolves sda with a pull-up and feeds it back
`timescale 1ns/1ps
module shc_master #(
   parameter int Q = 101
) (
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic start();
      #Q sda_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_o = 1'b0;
      #Q scl_o = 1'b0;
   endtask : start
   task automatic stop();
      #Q sda_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q sda_o = 1'b1;
   endtask : stop
   // data moves only well inside the low phase, never at the scl edge
   task automatic bit_x(input logic b, output logic r);
      #Q sda_o = b;
      #Q scl_o = 1'b1;
      #Q r = sda_i;
      scl_o = 1'b0;
   endtask : bit_x
   task automatic put(input logic [7:0] d, output logic nak);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, nak);
   endtask : put
   task automatic get(output logic [7:0] d, input logic last);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(last, r);
   endtask : get
endmodule : shc_master

// file: tb/test_shc_top.sv
// testbench: heater, status word and readback of the sensor core
// assumes master model shc_master and the checker bound to shc_top
`timescale 1ns/1ps
module test_shc_top
   import shc_pkg::*;
;
   logic clk = 1'b0;
   logic lclk = 1'b0;
   logic rst = 1'b1;
   logic pin_n = 1'b1;
   logic hum = 1'b0;
   logic temp = 1'b0;
   logic scl, sda_m, sda_d, oe_n, heat;
   logic [15:0] stat;
   wire logic sda = sda_m & (oe_n | sda_d);
   int error_cnt = 0;
   int tests_run = 0;
   initial forever #4 clk = ~clk;
   initial begin
      #3.3;
      forever #7.5 lclk = ~lclk;
   end
   shc_top shc_top_i (.CORE_CLK_I(clk), .RST_I(rst), .LINK_CLK_I(lclk),
      .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_d), .SDA_OE_N_O(oe_n),
      .EXTERNAL_RESET_PIN_N_I(pin_n), .HUM_ALERT_I(hum),
      .TEMP_ALERT_I(temp), .HEATER_ON_O(heat), .STATUS_O(stat));
   shc_master shc_master_i (.sda_i(sda), .scl_o(scl), .sda_o(sda_m));
   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction : crc8
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic results();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   // write transfer: address, two command bytes, optional crc byte
   task automatic cmd(input logic [7:0] h, input logic [7:0] l,
         input logic [8:0] c, input logic nak);
      logic a;
      logic n;
      shc_master_i.start();
      shc_master_i.put({TARGET_ADDR, 1'b0}, a);
      chk({15'h0000, a}, {15'h0000, nak});
      if (!a) begin
         shc_master_i.put(h, n);
         shc_master_i.put(l, n);
         if (c[8]) shc_master_i.put(c[7:0], n);
      end
      shc_master_i.stop();
      repeat (40) @(posedge clk);
   endtask : cmd
   task automatic rd(input logic [15:0] exp);
      logic a;
      logic [7:0] hi, lo, c;
      cmd(CMD_READ_MSB, CMD_READ_LSB, 9'h000, 1'b0);
      shc_master_i.start();
      shc_master_i.put({TARGET_ADDR, 1'b1}, a);
      shc_master_i.get(hi, 1'b0);
      shc_master_i.get(lo, 1'b0);
      shc_master_i.get(c, 1'b1);
      shc_master_i.stop();
      chk({15'h0000, a}, 16'h0000);
      chk({hi, lo}, exp);
      chk({8'h00, c}, {8'h00, crc8(exp)});
   endtask : rd
   task automatic alert(input logic h, input logic t);
      @(posedge clk);
      hum <= h;
      temp <= t;
      @(posedge clk);
      hum <= 1'b0;
      temp <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : alert
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      chk(stat, 16'h0010);
      cmd(CMD_GROUP_MSB, CMD_HEATER_ON_LSB, 9'h000, 1'b0);
      chk(stat, 16'h2010);
      chk({15'h0000, heat}, 16'h0001);
      rd(16'h2010);
      cmd(8'h12, 8'h34, 9'h000, 1'b0);
      chk(stat, 16'h2012);
      cmd(CMD_GROUP_MSB, CMD_HEATER_OFF_LSB, 9'h000, 1'b0);
      chk(stat, 16'h0010);
      cmd(CMD_GROUP_MSB, CMD_HEATER_OFF_LSB,
         {1'b1, ~crc8({CMD_GROUP_MSB, CMD_HEATER_OFF_LSB})}, 1'b0);
      chk(stat, 16'h0011);
      cmd(CMD_GROUP_MSB, CMD_HEATER_OFF_LSB,
         {1'b1, crc8({CMD_GROUP_MSB, CMD_HEATER_OFF_LSB})}, 1'b0);
      chk(stat, 16'h0010);
      alert(1'b1, 1'b0);
      chk(stat, 16'h8810);
      alert(1'b0, 1'b1);
      chk(stat, 16'h8C10);
      cmd(CMD_GROUP_MSB, CMD_CLEAR_LSB, 9'h000, 1'b0);
      chk(stat, 16'h0000);
      rd(16'h0000);
      cmd(CMD_GROUP_MSB, CMD_HEATER_ON_LSB, 9'h000, 1'b0);
      chk(stat, 16'h2000);
      @(posedge clk);
      pin_n <= 1'b0;
      cmd(8'h12, 8'h34, 9'h000, 1'b1);
      @(posedge clk);
      pin_n <= 1'b1;
      repeat (10) @(posedge clk);
      chk(stat, 16'h0010);
      results();
   end
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      $display("BAD %0t run timed out", $time);
      results();
   end
endmodule : test_shc_top
